// >>> bcam_pkg.sv
// Constants and field layout for the channel A break match block
package bcam_pkg;
   // Register and monitor port widths
   localparam int BCAM_AW = 8;
   localparam int BCAM_DW = 16;
   localparam int BCAM_BUSW = 32;
   // Register offsets, byte addresses of 16-bit registers
   localparam logic [7:0] OFF_ADDR_HI = 8'h40;
   localparam logic [7:0] OFF_ADDR_LO = 8'h42;
   localparam logic [7:0] OFF_MASK_HI = 8'h44;
   localparam logic [7:0] OFF_MASK_LO = 8'h46;
   localparam logic [7:0] OFF_CYC_COND = 8'h48;
   localparam logic [7:0] OFF_CTRL = 8'h78;
   localparam logic [7:0] OFF_IRQ_STS = 8'h7a;
   localparam logic [7:0] OFF_IRQ_MSK = 8'h7c;
   localparam logic [7:0] OFF_CAP_HI = 8'h7e;
   localparam logic [7:0] OFF_CAP_LO = 8'h80;
   // Reset value shared by every register
   localparam logic [15:0] RST_ZERO = 16'h0000;
   // Bus cycle condition fields
   localparam int CC_MST_HI = 7;
   localparam int CC_MST_LO = 6;
   localparam int CC_FD_HI = 5;
   localparam int CC_FD_LO = 4;
   localparam int CC_DIR_HI = 3;
   localparam int CC_DIR_LO = 2;
   localparam int CC_SZ_HI = 1;
   localparam int CC_SZ_LO = 0;
   localparam logic [15:0] CC_WR_MASK = 16'h00ff;
   // Control register fields
   localparam int CTL_PROC_FLAG = 15;
   localparam int CTL_PERI_FLAG = 14;
   localparam int CTL_EXT_EN = 13;
   // Interrupt status and mask fields
   localparam int IRQ_PROC = 0;
   localparam int IRQ_PERI = 1;
   localparam int IRQ_W = 2;
   // Bus master codes on the monitor port
   localparam logic [1:0] MST_PROC = 2'h0;
   localparam logic [1:0] MST_DMA = 2'h1;
   localparam logic [1:0] MST_EXT = 2'h2;
   // Operand size codes, same as the size select field
   localparam logic [1:0] SZ_NONE = 2'h0;
   localparam logic [1:0] SZ_BYTE = 2'h1;
   localparam logic [1:0] SZ_WORD = 2'h2;
   localparam logic [1:0] SZ_LONG = 2'h3;

   // Two-bit select: low bit enables class a, high bit class b
   function automatic logic bcam_sel_hit(input logic [1:0] sel, input logic is_a,
                                         input logic is_b);
      return (sel[0] & is_a) | (sel[1] & is_b);
   endfunction
endpackage

// >>> bcam_addr_cmp.sv
// Masked 32-bit address comparator for the break channel
`timescale 1ns/1ns
module bcam_addr_cmp
   import bcam_pkg::*;
(
   input wire logic [BCAM_BUSW-1:0] bus_addr,
   input wire logic [BCAM_BUSW-1:0] brk_addr,
   input wire logic [BCAM_BUSW-1:0] brk_mask,
   output logic hit
);
   // A set mask bit removes that bit from the compare
   always_comb begin
      hit = (((bus_addr ^ brk_addr) & ~brk_mask) == '0);
   end
endmodule // bcam_addr_cmp

// >>> bcam_top.sv
// Channel A break match: registers, cycle compare, flags, interrupt
`timescale 1ns/1ns
module bcam_top
   import bcam_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [BCAM_AW-1:0] reg_addr,
   input wire logic [BCAM_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [BCAM_DW-1:0] reg_rdata,
   input wire logic bus_valid,
   input wire logic [BCAM_BUSW-1:0] bus_addr,
   input wire logic [1:0] bus_master,
   input wire logic bus_fetch,
   input wire logic bus_write,
   input wire logic [1:0] bus_size,
   output logic break_req,
   output logic break_irq
);
   // Programmed condition registers
   logic [15:0] addr_hi_q;
   logic [15:0] addr_lo_q;
   logic [15:0] mask_hi_q;
   logic [15:0] mask_lo_q;
   logic [15:0] cyc_cond_q;
   // Control bits
   logic proc_match_flag_a_q;
   logic periph_match_flag_a_q;
   logic ext_master_break_enable_q;
   // Interrupt status, mask and match capture
   logic [IRQ_W-1:0] irq_sts_q;
   logic [IRQ_W-1:0] irq_sts_d;
   logic [IRQ_W-1:0] irq_msk_q;
   logic [IRQ_W-1:0] irq_msk_d;
   logic [31:0] cap_addr_q;
   // Output registers
   logic [15:0] rdata_q;
   logic break_req_q;
   logic irq_q;
   // Decoded writes
   logic wr_addr_hi;
   logic wr_addr_lo;
   logic wr_mask_hi;
   logic wr_mask_lo;
   logic wr_cyc;
   logic wr_ctrl;
   logic wr_sts;
   logic wr_msk;
   // Compare terms
   logic [31:0] brk_addr;
   logic [31:0] brk_mask;
   logic addr_hit;
   logic [1:0] sel_master;
   logic [1:0] sel_fd;
   logic [1:0] sel_dir;
   logic [1:0] sel_size;
   logic is_proc;
   logic is_peri;
   logic master_hit;
   logic fd_hit;
   logic dir_hit;
   logic [1:0] eff_size;
   logic size_hit;
   logic cyc_hit;
   logic hit_proc;
   logic hit_peri;

   // Write strobe decode; only full 16-bit lanes exist on this port
   always_comb begin
      wr_addr_hi = reg_wr && (reg_addr == OFF_ADDR_HI);
      wr_addr_lo = reg_wr && (reg_addr == OFF_ADDR_LO);
      wr_mask_hi = reg_wr && (reg_addr == OFF_MASK_HI);
      wr_mask_lo = reg_wr && (reg_addr == OFF_MASK_LO);
      wr_cyc = reg_wr && (reg_addr == OFF_CYC_COND);
      wr_ctrl = reg_wr && (reg_addr == OFF_CTRL);
      wr_sts = reg_wr && (reg_addr == OFF_IRQ_STS);
      wr_msk = reg_wr && (reg_addr == OFF_IRQ_MSK);
   end

   // Break address halves; high half is bits 31..16
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         addr_hi_q <= RST_ZERO;
         addr_lo_q <= RST_ZERO;
      end else if (clk_en) begin
         if (wr_addr_hi) begin
            addr_hi_q <= reg_wdata;
         end
         if (wr_addr_lo) begin
            addr_lo_q <= reg_wdata;
         end
      end
   end

   // Address mask halves
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mask_hi_q <= RST_ZERO;
         mask_lo_q <= RST_ZERO;
      end else if (clk_en) begin
         if (wr_mask_hi) begin
            mask_hi_q <= reg_wdata;
         end
         if (wr_mask_lo) begin
            mask_lo_q <= reg_wdata;
         end
      end
   end

   // Cycle condition register; upper byte is forced to zero on write
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cyc_cond_q <= RST_ZERO;
      end else if (clk_en && wr_cyc) begin
         cyc_cond_q <= reg_wdata & CC_WR_MASK;
      end
   end

   // External master enable, plain read/write bit
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ext_master_break_enable_q <= 1'b0;
      end else if (clk_en && wr_ctrl) begin
         ext_master_break_enable_q <= reg_wdata[CTL_EXT_EN];
      end
   end

   // Match flags: hardware only sets, software may write zero to clear.
   // A match in the clearing cycle wins so no event is lost.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         proc_match_flag_a_q <= 1'b0;
         periph_match_flag_a_q <= 1'b0;
      end else if (clk_en) begin
         if (hit_proc) begin
            proc_match_flag_a_q <= 1'b1;
         end else if (wr_ctrl && !reg_wdata[CTL_PROC_FLAG]) begin
            proc_match_flag_a_q <= 1'b0;
         end
         if (hit_peri) begin
            periph_match_flag_a_q <= 1'b1;
         end else if (wr_ctrl && !reg_wdata[CTL_PERI_FLAG]) begin
            periph_match_flag_a_q <= 1'b0;
         end
      end
   end

   // Assemble the 32-bit compare operands
   assign brk_addr = {addr_hi_q, addr_lo_q};
   assign brk_mask = {mask_hi_q, mask_lo_q};

   // Masked address compare
   bcam_addr_cmp u_addr_cmp (
      .bus_addr(bus_addr),
      .brk_addr(brk_addr),
      .brk_mask(brk_mask),
      .hit(addr_hit)
   );

   // Field extraction from the cycle condition register
   assign sel_master = cyc_cond_q[CC_MST_HI:CC_MST_LO];
   assign sel_fd = cyc_cond_q[CC_FD_HI:CC_FD_LO];
   assign sel_dir = cyc_cond_q[CC_DIR_HI:CC_DIR_LO];
   assign sel_size = cyc_cond_q[CC_SZ_HI:CC_SZ_LO];

   // Master class; external cycles are peripheral only when enabled
   always_comb begin
      is_proc = (bus_master == MST_PROC);
      is_peri = (bus_master == MST_DMA) ||
                ((bus_master == MST_EXT) && ext_master_break_enable_q);
   end

   // Per-field hits; select 00 in the master, fetch/data or direction field blocks the channel
   always_comb begin
      master_hit = bcam_sel_hit(sel_master, is_proc, is_peri);
      fd_hit = bcam_sel_hit(sel_fd, bus_fetch, !bus_fetch);
      dir_hit = bcam_sel_hit(sel_dir, !bus_write, bus_write);
   end

   // Fetches always compare as word, whatever the bus width was.
   // Data cycles use the size the master issued.
   always_comb begin
      eff_size = bus_fetch ? SZ_WORD : bus_size;
      size_hit = (sel_size == SZ_NONE) || (sel_size == eff_size);
   end

   // All enabled conditions in the same bus cycle
   always_comb begin
      cyc_hit = bus_valid && addr_hit && master_hit && fd_hit && dir_hit && size_hit;
      hit_proc = cyc_hit && is_proc;
      hit_peri = cyc_hit && is_peri;
   end

   // Break request pulse, one cycle after the matching bus cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         break_req_q <= 1'b0;
      end else if (clk_en) begin
         break_req_q <= cyc_hit;
      end
   end

   // Capture the address of the most recent match for the handler
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cap_addr_q <= 32'h0000_0000;
      end else if (clk_en && cyc_hit) begin
         cap_addr_q <= bus_addr;
      end
   end

   // Sticky status, write one to clear; a new event beats the clear
   always_comb begin
      irq_sts_d = irq_sts_q;
      if (wr_sts) begin
         irq_sts_d = irq_sts_d & ~reg_wdata[IRQ_W-1:0];
      end
      irq_sts_d[IRQ_PROC] = irq_sts_d[IRQ_PROC] | hit_proc;
      irq_sts_d[IRQ_PERI] = irq_sts_d[IRQ_PERI] | hit_peri;
   end

   // Interrupt mask; a one lets that event reach the output
   always_comb begin
      irq_msk_d = irq_msk_q;
      if (wr_msk) begin
         irq_msk_d = reg_wdata[IRQ_W-1:0];
      end
   end

   // Status and mask storage
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_sts_q <= '0;
         irq_msk_q <= '0;
      end else if (clk_en) begin
         irq_sts_q <= irq_sts_d;
         irq_msk_q <= irq_msk_d;
      end
   end

   // Level interrupt, registered from next-state so it tracks status
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else if (clk_en) begin
         irq_q <= |(irq_sts_d & irq_msk_d);
      end
   end

   // Read data valid only in the cycle after the strobe; else zero.
   // Unmapped offsets return zero, reserved bits read zero.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_q <= RST_ZERO;
      end else if (clk_en) begin
         rdata_q <= RST_ZERO;
         if (reg_rd) begin
            unique case (reg_addr)
               OFF_ADDR_HI: rdata_q <= addr_hi_q;
               OFF_ADDR_LO: rdata_q <= addr_lo_q;
               OFF_MASK_HI: rdata_q <= mask_hi_q;
               OFF_MASK_LO: rdata_q <= mask_lo_q;
               OFF_CYC_COND: rdata_q <= cyc_cond_q;
               OFF_CTRL: begin
                  rdata_q[CTL_PROC_FLAG] <= proc_match_flag_a_q;
                  rdata_q[CTL_PERI_FLAG] <= periph_match_flag_a_q;
                  rdata_q[CTL_EXT_EN] <= ext_master_break_enable_q;
               end
               OFF_IRQ_STS: rdata_q[IRQ_W-1:0] <= irq_sts_q;
               OFF_IRQ_MSK: rdata_q[IRQ_W-1:0] <= irq_msk_q;
               OFF_CAP_HI: rdata_q <= cap_addr_q[31:16];
               OFF_CAP_LO: rdata_q <= cap_addr_q[15:0];
               default: rdata_q <= RST_ZERO;
            endcase
         end
      end
   end

   // Outputs straight from flops
   assign reg_rdata = rdata_q;
   assign break_req = break_req_q;
   assign break_irq = irq_q;
endmodule // bcam_top

// >>> bcam_checker.sv
// Port assertions for the channel A break match block
`timescale 1ns/1ns
module bcam_checker
   import bcam_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [BCAM_AW-1:0] reg_addr,
   input wire logic [BCAM_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [BCAM_DW-1:0] reg_rdata,
   input wire logic bus_valid,
   input wire logic [1:0] bus_master,
   input wire logic bus_fetch,
   input wire logic [1:0] bus_size,
   input wire logic break_req,
   input wire logic break_irq
);
   logic [7:0] cc_q;
   // Shadow of the cycle fields; upper byte never stored
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cc_q <= 8'h00;
      end else if (clk_en && reg_wr && reg_addr == OFF_CYC_COND) begin
         cc_q <= reg_wdata[7:0];
      end
   end
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (rst);
   rst_clear_a:
      assert property (disable iff (1'b0) rst |=> !break_req && !break_irq && reg_rdata == 16'h0)
      else $error("outputs not cleared in reset");
   cond_read_a:
      assert property (clk_en && reg_rd && reg_addr == OFF_CYC_COND |=> reg_rdata == {8'h00, $past(cc_q)})
      else $error("cycle register read wrong");
   no_cycle_a:
      assert property (clk_en && !bus_valid |=> !break_req) else $error("break without bus cycle");
   mst_off_a:
      assert property (clk_en && bus_valid && (cc_q[7:6] == 2'h0 || bus_master == 2'h3) |=> !break_req)
      else $error("break with no master selected");
   fd_off_a:
      assert property (clk_en && bus_valid && cc_q[5:4] == 2'h0 |=> !break_req)
      else $error("break with fetch/data off");
   fetch_size_a:
      assert property (clk_en && bus_valid && bus_fetch && cc_q[0] |=> !break_req)
      else $error("fetch matched non-word size");
   size_miss_a:
      assert property (clk_en && bus_valid && !bus_fetch && cc_q[1:0] != 2'h0
         && bus_size != cc_q[1:0] |=> !break_req) else $error("break on wrong size");
   irq_cause_a:
      assert property ($rose(break_irq) |-> break_req || $past(reg_wr))
      else $error("interrupt rose without cause");
endmodule // bcam_checker

bind bcam_top bcam_checker i_chk (.core_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .bus_valid, .bus_master, .bus_fetch, .bus_size, .break_req, .break_irq);

// >>> bcam_bus_model.sv
// Bus cycle source for processor, DMA and external master cycles
`timescale 1ns/1ns
module bcam_bus_model
   import bcam_pkg::*;
(
   output logic bus_valid,
   output logic [BCAM_BUSW-1:0] bus_addr,
   output logic [1:0] bus_master,
   output logic bus_fetch,
   output logic bus_write,
   output logic [1:0] bus_size,
   input wire logic core_clk
);
   // Idle at time zero
   initial begin
      bus_valid = 1'b0;
      bus_addr = '0;
      bus_master = 2'h3;
      bus_fetch = 1'b0;
      bus_write = 1'b0;
      bus_size = 2'h0;
   end
   // One sample per cycle; idle address, fetch, write and size lines flip so stale values never pose as valid
   task automatic issue(input logic [31:0] a, input logic [1:0] m, input logic f, w,
      input logic [1:0] s);
      @(posedge core_clk);
      bus_valid <= 1'b1;
      bus_addr <= a;
      bus_master <= m;
      bus_fetch <= f;
      bus_write <= w;
      bus_size <= s;
      @(posedge core_clk);
      bus_valid <= 1'b0;
      bus_addr <= ~a;
      bus_fetch <= ~f;
      bus_write <= ~w;
      bus_size <= ~s;
   endtask
endmodule // bcam_bus_model

// >>> tb_top.sv
// Self-checking testbench for the channel A break match block
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
   $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_top;
   import bcam_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [BCAM_AW-1:0] reg_addr = '0;
   logic [BCAM_DW-1:0] reg_wdata = '0;
   logic [BCAM_DW-1:0] reg_rdata;
   logic bus_valid, bus_fetch, bus_write, break_req, break_irq;
   logic [BCAM_BUSW-1:0] bus_addr;
   logic [1:0] bus_master, bus_size;
   int fail_count = 0;
   int checks_done = 0;
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   bcam_top i_dut (.core_clk, .rst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .bus_valid, .bus_addr, .bus_master, .bus_fetch, .bus_write, .bus_size,
      .break_req, .break_irq);
   bcam_bus_model i_src (.core_clk, .bus_valid, .bus_addr, .bus_master, .bus_fetch,
      .bus_write, .bus_size);
   // Register writes are always 16 bits wide
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [15:0] e, input string n);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(n, e, reg_rdata)
   endtask
   task automatic bus(input logic [31:0] a, input logic [1:0] m, input logic f, w,
      input logic [1:0] s, input logic e);
      i_src.issue(a, m, f, w, s);
      #1;
      `CHK("break_req", e, break_req)
   endtask
   // Expected match, address assumed equal
   function automatic logic hit(input logic [7:0] c, input logic en, input logic [1:0] m,
      input logic f, w, input logic [1:0] s);
      logic [1:0] es;
      es = f ? SZ_WORD : s;
      return ((c[6] & m == MST_PROC) | (c[7] & (m == MST_DMA | (m == MST_EXT & en))))
         & ((c[4] & f) | (c[5] & !f)) & ((c[2] & !w) | (c[3] & w))
         & (c[1:0] == SZ_NONE | c[1:0] == es);
   endfunction
   task automatic t_reset();
      logic [7:0] offs[6] = '{OFF_ADDR_HI, OFF_ADDR_LO, OFF_MASK_HI, OFF_MASK_LO, OFF_CYC_COND, 8'h50};
      foreach (offs[i]) rd(offs[i], 16'h0000, "reset value");
      $display("t_reset done");
   endtask
   task automatic t_regs();
      wr(OFF_ADDR_HI, 16'h1234);
      wr(OFF_ADDR_LO, 16'h5678);
      wr(OFF_MASK_LO, 16'h00ff);
      wr(OFF_CYC_COND, 16'hffff);
      rd(OFF_ADDR_HI, 16'h1234, "addr_hi");
      rd(OFF_ADDR_LO, 16'h5678, "addr_lo");
      rd(OFF_MASK_LO, 16'h00ff, "mask_lo");
      rd(OFF_CYC_COND, 16'h00ff, "cycle_cond");
      $display("t_regs done");
   endtask
   task automatic t_mask();
      wr(OFF_CYC_COND, 16'h00fc);
      bus(32'h1234_56ab, MST_PROC, 1'b0, 1'b0, SZ_WORD, 1'b1);
      bus(32'h1234_57ab, MST_PROC, 1'b0, 1'b0, SZ_WORD, 1'b0);
      bus(32'h1235_5678, MST_PROC, 1'b0, 1'b0, SZ_WORD, 1'b0);
      $display("t_mask done");
   endtask
   task automatic t_irq();
      wr(OFF_CTRL, 16'h0000);
      wr(OFF_IRQ_STS, 16'h0003);
      wr(OFF_IRQ_MSK, 16'h0000);
      bus(32'h1234_5600, MST_PROC, 1'b0, 1'b1, SZ_LONG, 1'b1);
      `CHK("break_irq", 1'b0, break_irq)
      rd(OFF_CTRL, 16'h8000, "ctrl");
      wr(OFF_CTRL, 16'h8000);
      rd(OFF_CTRL, 16'h8000, "ctrl");
      wr(OFF_IRQ_MSK, 16'h0001);
      @(posedge core_clk);
      #1;
      `CHK("break_irq", 1'b1, break_irq)
      wr(OFF_IRQ_STS, 16'h0001);
      @(posedge core_clk);
      #1;
      `CHK("break_irq", 1'b0, break_irq)
      $display("t_irq done");
   endtask
   // Peripheral match, capture, status and mask readback, freeze, fetch size
   task automatic t_periph();
      wr(OFF_CTRL, 16'h0000);
      rd(OFF_CTRL, 16'h0000, "ctrl cleared");
      wr(OFF_MASK_HI, 16'hffff);
      rd(OFF_MASK_HI, 16'hffff, "mask_hi");
      wr(OFF_CYC_COND, 16'h00bc);
      bus(32'hffff_5601, MST_DMA, 1'b0, 1'b1, SZ_BYTE, 1'b1);
      bus(32'hffff_5601, MST_PROC, 1'b0, 1'b0, SZ_WORD, 1'b0);
      bus(32'hffff_5601, MST_EXT, 1'b0, 1'b0, SZ_WORD, 1'b0);
      rd(OFF_CTRL, 16'h4000, "ctrl periph flag");
      rd(OFF_IRQ_STS, 16'h0002, "irq status");
      rd(OFF_IRQ_MSK, 16'h0001, "irq mask");
      rd(OFF_CAP_HI, 16'hffff, "capture hi");
      rd(OFF_CAP_LO, 16'h5601, "capture lo");
      `CHK("break_irq", 1'b0, break_irq)
      // Frozen clock enable: neither the match nor the clear may land
      @(posedge core_clk);
      clk_en <= 1'b0;
      bus(32'hffff_56aa, MST_DMA, 1'b0, 1'b1, SZ_BYTE, 1'b0);
      wr(OFF_IRQ_STS, 16'h0002);
      @(posedge core_clk);
      clk_en <= 1'b1;
      rd(OFF_IRQ_STS, 16'h0002, "frozen status");
      rd(OFF_CAP_LO, 16'h5601, "frozen capture");
      // Fetch break with the low size bit kept clear
      wr(OFF_CYC_COND, 16'h00d6);
      bus(32'hffff_5600, MST_PROC, 1'b1, 1'b0, SZ_LONG, 1'b1);
      $display("t_periph done");
   endtask
   // Every condition code against every master, kind, direction and nonzero size code
   task automatic t_sweep();
      for (int i = 0; i < 512; i++) begin
         wr(OFF_CTRL, i[8] ? 16'h2000 : 16'h0000);
         wr(OFF_CYC_COND, {8'h00, i[7:0]});
         for (int k = 0; k < 64; k++) begin
            if (k[1:0] != 2'h0) begin
               bus(32'h1234_5611, k[5:4], k[3], k[2], k[1:0],
                  hit(i[7:0], i[8], k[5:4], k[3], k[2], k[1:0]));
            end
         end
      end
      $display("t_sweep done");
   endtask
   // Reset in mid-run must clear the programmed registers again
   task automatic t_midreset();
      @(posedge core_clk);
      rst <= 1'b1;
      @(posedge core_clk);
      rst <= 1'b0;
      rd(OFF_ADDR_LO, 16'h0000, "addr_lo after reset");
      rd(OFF_MASK_HI, 16'h0000, "mask_hi after reset");
      rd(OFF_CYC_COND, 16'h0000, "cycle_cond after reset");
      `CHK("break_irq", 1'b0, break_irq)
      $display("t_midreset done");
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_regs();
      t_mask();
      t_irq();
      t_periph();
      t_sweep();
      t_midreset();
      end_of_test();
   end
   // Tests need about 52k cycles; limit at 95k
   initial begin
      #950000;
      fail_count++;
      end_of_test();
   end
endmodule // tb_top
